//--- ucode_map.svh
// Widths, register offsets, reset values and decode constants of the decoder.
`ifndef UCODE_MAP_SVH
`define UCODE_MAP_SVH

`define UADDR_W 10
`define STACK_DEPTH 4
`define REG_DATA_W 16
`define REG_ADDR_W 2

`define REG_TRAP_ADDR 2'h0
`define REG_STATUS 2'h1
`define REG_FLAGS 2'h2

`define TRAP_ADDR_RST 10'h3F0
`define UADDR_RST 10'h000
`define FLAGS_RST 8'h00

`define MASK_ZEROS 2'h0
`define MASK_ONES 2'h1

`define WSEL_LEFT 2'h0
`define WSEL_RIGHT 2'h1
`define WSEL_FULL 2'h2
`define WSEL_SHIFT 2'h3

`define SRC_FLOAT_A 3'h2
`define SRC_FLOAT_B 3'h5
`define SRC_FLOAT_C 3'h7

`define DEST_UNIT 2'h1
`define DEST_QUEUE 2'h2
`define DEST_CYL 2'h3

`define BUSC_END 2'h1
`define BUSC_READ 2'h2
`define BUSC_WRITE 2'h3

`define GRP_PULSE 2'h0
`define GRP_CTL 2'h1
`define GRP_DRIVE 2'h2
`define GRP_FLAGS 2'h3

`define G0_CLK_STOP 4'h1
`define G0_MASTER_CLR 4'h2
`define G0_MSB_LOAD 4'h3
`define G0_STOP_IF 4'h4
`define G0_MSB_INC 4'h5
`define G0_CLR_SECT 4'h6
`define G0_START_IF 4'h8
`define G0_TIMER_RST 4'hA
`define G0_RST_DREADY 4'hC
`define G0_CLR_DISK 4'hE
`define G0_VALID 16'h557E
`define G0_STROBED 16'h1174

`endif

//--- ucode_pkg.sv
// Types shared by the microinstruction decoder, its checks, its microprogram store and its bench.
package ucode_pkg;

   typedef enum logic [2:0] {
      BR_INC = 3'h0,
      BR_JMP = 3'h1,
      BR_JMP_T = 3'h2,
      BR_JMP_F = 3'h3,
      BR_CALL = 3'h4,
      BR_RET_T = 3'h5,
      BR_RET_F = 3'h6,
      BR_RET = 3'h7
   } branch_e;

   // Bit 0 of the microinstruction is the most significant member here.
   typedef struct packed {
      logic clk_stop;
      logic [6:0] func;
      logic [1:0] word_sel;
      logic [1:0] mask_sel;
      logic carry;
      logic [2:0] src;
      logic slave_en;
      branch_e branch;
      logic [1:0] dest;
      logic [9:0] next_address_field;
      logic [1:0] bus_ctl;
      logic [1:0] group;
      logic [3:0] special;
   } ucode_s;

   typedef struct packed {
      logic diag_fault;
      logic fault;
      logic busy;
      logic bus_interrupt;
      logic direct_mode;
      logic iface_write;
      logic diag_clock_flag;
      logic diag_mode_flag;
   } ctl_flags_s;

   typedef struct packed {
      logic drive_address_strobe;
      logic head_select_line;
      logic spare_output_two;
      logic read;
      logic write_gate;
      logic erase;
      logic restore;
      logic spare_output_one;
   } drive_lines_s;

   typedef struct packed {
      logic spare_flag;
      logic queue_stop_flag;
      logic crc_preset;
      logic crc_out_en;
   } crc_flags_s;

   typedef struct packed {
      logic cyl_addr_load;
      logic queue_input_load;
      logic unit_select_load;
   } dest_load_s;

   typedef struct packed {
      logic master_write_cmd;
      logic master_read_cmd;
      logic slave_cycle_end_cmd;
   } bus_cmd_s;

endpackage : ucode_pkg

//--- ret_stack.sv
// Push/pop return stack for microprogram return addresses.
`timescale 1ns/10ps
module ret_stack #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 10,
   parameter int CNT_W = 3
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top,
   output logic [CNT_W-1:0] depth
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [CNT_W-1:0] depth_reg;
   logic [CNT_W-1:0] depth_next;

   // Overflow drops the oldest entry; an empty pop returns the stale top.
   assign depth_next = (push && !pop && depth_reg != CNT_W'(DEPTH)) ? depth_reg + 1'b1 :
                       (pop && !push && depth_reg != '0) ? depth_reg - 1'b1 : depth_reg;
   assign top = mem_reg[0];
   assign depth = depth_reg;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         depth_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         depth_reg <= depth_next;
         if (push) begin
            mem_reg[0] <= push_data;
         end
         for (int i = 1; i < DEPTH; i++) begin
            if (push && !pop) begin
               mem_reg[i] <= mem_reg[i-1];
            end else if (pop && !push) begin
               mem_reg[i-1] <= mem_reg[i];
            end
         end
      end
   end
endmodule : ret_stack

//--- disk_ctrl_microinstruction_decoder.sv
// Microinstruction decoder and next-address sequencer of the disk controller.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "ucode_map.svh"

// Function
// - Code 100 pushes address+1, jumps to field.
// - Codes 101/110 return on test, else jump.
// - Code 111 returns to stacked address always.
// - Four-deep push/pop stack, adder and multiplexer.
// - Slave trap stacks branch address, uses trap address.
// - Bit 16 enables slave flip-flops.
// - Slave enable follows microprogram idle/operation state.
// - Destination 01 unit select, 10 queue input.
// - Bus code 01 ends the slave cycle.
// - Bus codes 10/11 master read and write.
// - Bits 34-35 pick one special group.
// - Group 00 issues pulse commands.
// - Group 01 sets or resets control flags.
// - Group 10 sets or resets drive lines.
// - Group 11 gives independent CRC and queue flags.
// - Strobed commands act on the following clock.
// - Word select picks left, right, full, shift.
// - Mask select: zeros, ones or immediate operand.
// - Bit 12 is carry-in or shift fill.
// - Bits 13-15 enable one source or float.
// - Immediate bits are inverted onto the mask.
// - Full word sign-extends immediate into left byte.
// - Codes 000 to 011 increment or branch.
// - Destination 11 loads the cylinder register.
// - Bit 0 stops the array clock only.
module disk_ctrl_microinstruction_decoder #(
   parameter int ADDR_W = `UADDR_W,
   parameter int STACK_DEPTH = `STACK_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire ucode_pkg::ucode_s ucode,
   input wire logic branch_test_bit,
   input wire logic slave_request,
   input wire logic [`REG_ADDR_W-1:0] reg_addr,
   input wire logic [`REG_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`REG_DATA_W-1:0] reg_rdata,
   output logic [ADDR_W-1:0] micro_addr,
   output logic slave_trap,
   output logic slave_enable,
   output logic array_clk_en,
   output logic [1:0] word_sel,
   output logic [15:0] mask_bus,
   output logic carry_in,
   output logic shift_fill,
   output logic [7:0] src_enable,
   output ucode_pkg::dest_load_s dest_load,
   output ucode_pkg::bus_cmd_s bus_cmd,
   output logic [15:0] group0_pulse,
   output ucode_pkg::ctl_flags_s ctl_flags,
   output ucode_pkg::drive_lines_s drive_lines,
   output ucode_pkg::crc_flags_s crc_flags
);
   localparam int CNT_W = $clog2(STACK_DEPTH + 1);

   // Sequencer state.
   logic [ADDR_W-1:0] micro_addr_reg;
   logic [ADDR_W-1:0] micro_addr_next;
   logic [ADDR_W-1:0] addr_inc;
   logic [ADDR_W-1:0] branch_target;
   logic [ADDR_W-1:0] seq_addr;
   logic [ADDR_W-1:0] stack_top;
   logic [ADDR_W-1:0] push_data;
   logic [CNT_W-1:0] stack_depth;
   logic [ADDR_W-1:0] trap_addr_reg;
   logic trap_hit;
   logic ret_taken;
   logic stack_push;
   logic stack_pop;

   // Array control.
   logic [7:0] imm_operand;
   logic [7:0] mask_byte;
   logic [15:0] mask_next;
   logic imm_selected;
   logic src_floats;
   logic [7:0] src_next;

   // Subfield and special decode.
   logic subfields_free;
   logic [3:0] grp_hit;
   logic [15:0] g0_decode;
   logic [15:0] g0_strobe_reg;
   logic [7:0] sf_select;
   logic [7:0] ctl_next;
   logic [7:0] drive_next;
   ucode_pkg::dest_load_s dest_decode;
   ucode_pkg::dest_load_s dest_strobe_reg;
   ucode_pkg::bus_cmd_s bus_next;
   ucode_pkg::crc_flags_s crc_next;

   // Register port.
   logic trap_wr;
   logic [`REG_DATA_W-1:0] rdata_next;

   // Registered outputs.
   logic slave_trap_reg;
   logic slave_enable_reg;
   logic array_clk_en_reg;
   logic [1:0] word_sel_reg;
   logic [15:0] mask_bus_reg;
   logic carry_in_reg;
   logic shift_fill_reg;
   logic [7:0] src_enable_reg;
   ucode_pkg::dest_load_s dest_load_reg;
   ucode_pkg::bus_cmd_s bus_cmd_reg;
   logic [15:0] group0_pulse_reg;
   logic [7:0] ctl_flags_reg;
   logic [7:0] drive_lines_reg;
   ucode_pkg::crc_flags_s crc_flags_reg;
   logic [`REG_DATA_W-1:0] reg_rdata_reg;

   ret_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(ADDR_W),
      .CNT_W(CNT_W)
   ) u_ret_stack (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .push(stack_push),
      .pop(stack_pop),
      .push_data(push_data),
      .top(stack_top),
      .depth(stack_depth)
   );

   // Next-address selection.
   assign addr_inc = ADDR_W'(micro_addr_reg + 1'b1);
   assign branch_target = ucode.next_address_field;
   assign ret_taken = (ucode.branch == ucode_pkg::BR_RET) ||
                      (ucode.branch == ucode_pkg::BR_RET_T && branch_test_bit) ||
                      (ucode.branch == ucode_pkg::BR_RET_F && !branch_test_bit);

   always_comb begin
      case (ucode.branch)
         ucode_pkg::BR_INC: seq_addr = addr_inc;
         ucode_pkg::BR_JMP: seq_addr = branch_target;
         ucode_pkg::BR_JMP_T: seq_addr = branch_test_bit ? branch_target : addr_inc;
         ucode_pkg::BR_JMP_F: seq_addr = branch_test_bit ? addr_inc : branch_target;
         ucode_pkg::BR_CALL: seq_addr = branch_target;
         ucode_pkg::BR_RET_T: seq_addr = ret_taken ? stack_top : branch_target;
         ucode_pkg::BR_RET_F: seq_addr = ret_taken ? stack_top : branch_target;
         ucode_pkg::BR_RET: seq_addr = stack_top;
         default: seq_addr = addr_inc;
      endcase
   end

   // A trap replaces the jump but keeps the return path, so the slave routine
   // can resume the interrupted flow with a plain return.
   assign trap_hit = slave_request && ucode.slave_en;
   assign stack_pop = ret_taken;
   assign stack_push = trap_hit || (ucode.branch == ucode_pkg::BR_CALL);
   assign push_data = trap_hit ? seq_addr : addr_inc;
   assign micro_addr_next = trap_hit ? trap_addr_reg : seq_addr;

   // Mask bus, word select and carry.
   assign imm_selected = ucode.mask_sel[1];
   assign imm_operand = {ucode.bus_ctl, ucode.group, ucode.special};
   assign mask_byte = (ucode.mask_sel == `MASK_ZEROS) ? 8'h00 :
                      (ucode.mask_sel == `MASK_ONES) ? 8'hFF :
                      ~imm_operand;
   assign mask_next = (ucode.word_sel == `WSEL_LEFT) ? {mask_byte, 8'h00} :
                      (ucode.word_sel == `WSEL_RIGHT) ? {8'h00, mask_byte} :
                      {{8{mask_byte[7]}}, mask_byte};

   // Three source codes leave the processor bus undriven.
   assign src_floats = (ucode.src == `SRC_FLOAT_A) || (ucode.src == `SRC_FLOAT_B) ||
                       (ucode.src == `SRC_FLOAT_C);
   assign src_next = src_floats ? 8'h00 : 8'(8'h01 << ucode.src);

   // Bits 32-39 act as command subfields only while no immediate is taken.
   assign subfields_free = !imm_selected;
   assign grp_hit = subfields_free ? 4'(4'h1 << ucode.group) : 4'h0;

   assign bus_next.slave_cycle_end_cmd = subfields_free && (ucode.bus_ctl == `BUSC_END);
   assign bus_next.master_read_cmd = subfields_free && (ucode.bus_ctl == `BUSC_READ);
   assign bus_next.master_write_cmd = subfields_free && (ucode.bus_ctl == `BUSC_WRITE);

   assign dest_decode.unit_select_load = (ucode.dest == `DEST_UNIT);
   assign dest_decode.queue_input_load = (ucode.dest == `DEST_QUEUE);
   assign dest_decode.cyl_addr_load = (ucode.dest == `DEST_CYL);

   // Group 0 pulses; codes outside the valid set are no-operations.
   assign g0_decode = grp_hit[`GRP_PULSE] ?
                      (16'(16'h0001 << ucode.special) & `G0_VALID) : 16'h0000;

   // Groups 1 and 2: code bits 36-38 pick the flip-flop, bit 39 is its new value.
   assign sf_select = 8'(8'h01 << ucode.special[3:1]);
   assign ctl_next = grp_hit[`GRP_CTL] ?
                     ((ctl_flags_reg & ~sf_select) | (ucode.special[0] ? sf_select : 8'h00)) :
                     ctl_flags_reg;
   assign drive_next = grp_hit[`GRP_DRIVE] ?
                       ((drive_lines_reg & ~sf_select) | (ucode.special[0] ? sf_select : 8'h00)) :
                       drive_lines_reg;

   assign crc_next.crc_out_en = grp_hit[`GRP_FLAGS] && ucode.special[3];
   assign crc_next.crc_preset = grp_hit[`GRP_FLAGS] && ucode.special[2];
   assign crc_next.queue_stop_flag = grp_hit[`GRP_FLAGS] && ucode.special[1];
   assign crc_next.spare_flag = grp_hit[`GRP_FLAGS] && ucode.special[0];

   // Register port decode.
   assign trap_wr = reg_wr && (reg_addr == `REG_TRAP_ADDR);
   assign rdata_next = !reg_rd ? '0 :
                       (reg_addr == `REG_TRAP_ADDR) ? `REG_DATA_W'(trap_addr_reg) :
                       (reg_addr == `REG_STATUS) ?
                       `REG_DATA_W'({slave_enable_reg, stack_depth, micro_addr_reg}) :
                       (reg_addr == `REG_FLAGS) ? {drive_lines_reg, ctl_flags_reg} : '0;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         micro_addr_reg <= `UADDR_RST;
         trap_addr_reg <= `TRAP_ADDR_RST;
         reg_rdata_reg <= '0;
      end else begin
         micro_addr_reg <= micro_addr_next;
         if (trap_wr) begin
            trap_addr_reg <= reg_wdata[ADDR_W-1:0];
         end
         reg_rdata_reg <= rdata_next;
      end
   end

   // Array and bus controls follow the word at the edge that ends its cycle.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         slave_trap_reg <= 1'b0;
         slave_enable_reg <= 1'b0;
         array_clk_en_reg <= 1'b0;
         word_sel_reg <= `WSEL_LEFT;
         mask_bus_reg <= 16'h0000;
         carry_in_reg <= 1'b0;
         shift_fill_reg <= 1'b0;
         src_enable_reg <= 8'h00;
         bus_cmd_reg <= '0;
      end else begin
         slave_trap_reg <= trap_hit;
         slave_enable_reg <= ucode.slave_en;
         array_clk_en_reg <= !ucode.clk_stop;
         word_sel_reg <= ucode.word_sel;
         mask_bus_reg <= mask_next;
         carry_in_reg <= ucode.carry && (ucode.word_sel != `WSEL_SHIFT);
         shift_fill_reg <= ucode.carry && (ucode.word_sel == `WSEL_SHIFT);
         src_enable_reg <= src_next;
         bus_cmd_reg <= bus_next;
      end
   end

   // Strobed commands pass one extra stage so they act a clock later.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         g0_strobe_reg <= 16'h0000;
         dest_strobe_reg <= '0;
         group0_pulse_reg <= 16'h0000;
         dest_load_reg <= '0;
         ctl_flags_reg <= `FLAGS_RST;
         drive_lines_reg <= `FLAGS_RST;
         crc_flags_reg <= '0;
      end else begin
         g0_strobe_reg <= g0_decode & `G0_STROBED;
         dest_strobe_reg <= dest_decode;
         group0_pulse_reg <= (g0_decode & ~`G0_STROBED) | g0_strobe_reg;
         dest_load_reg <= dest_strobe_reg;
         ctl_flags_reg <= ctl_next;
         drive_lines_reg <= drive_next;
         crc_flags_reg <= crc_next;
      end
   end

   assign micro_addr = micro_addr_reg;
   assign slave_trap = slave_trap_reg;
   assign slave_enable = slave_enable_reg;
   assign array_clk_en = array_clk_en_reg;
   assign word_sel = word_sel_reg;
   assign mask_bus = mask_bus_reg;
   assign carry_in = carry_in_reg;
   assign shift_fill = shift_fill_reg;
   assign src_enable = src_enable_reg;
   assign dest_load = dest_load_reg;
   assign bus_cmd = bus_cmd_reg;
   assign group0_pulse = group0_pulse_reg;
   assign ctl_flags = ctl_flags_reg;
   assign drive_lines = drive_lines_reg;
   assign crc_flags = crc_flags_reg;
   assign reg_rdata = reg_rdata_reg;

endmodule : disk_ctrl_microinstruction_decoder

//--- disk_ctrl_microinstruction_decoder_asserts.sv
// Concurrent checks on the ports of the microinstruction decoder.
`timescale 1ns/10ps
`include "ucode_map.svh"
module disk_ctrl_microinstruction_decoder_asserts #(
   parameter int ADDR_W = `UADDR_W,
   parameter int STACK_DEPTH = `STACK_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire ucode_pkg::ucode_s ucode,
   input wire logic branch_test_bit,
   input wire logic slave_request,
   input wire logic [ADDR_W-1:0] micro_addr,
   input wire logic slave_trap,
   input wire logic slave_enable,
   input wire logic array_clk_en,
   input wire logic [15:0] mask_bus,
   input wire logic carry_in,
   input wire logic [7:0] src_enable,
   input wire ucode_pkg::dest_load_s dest_load,
   input wire ucode_pkg::bus_cmd_s bus_cmd,
   input wire logic [15:0] group0_pulse,
   input wire ucode_pkg::ctl_flags_s ctl_flags,
   input wire ucode_pkg::crc_flags_s crc_flags
);
   localparam logic [ADDR_W-1:0] one_a = 1;
   localparam logic [15:0] g0_strobed = `G0_STROBED;
   wire logic take = ucode.slave_en && slave_request;
   wire logic t = branch_test_bit;
   wire logic [2:0] br = ucode.branch;
   wire logic [3:0] sp = ucode.special;
   wire logic [2:0] src = ucode.src;
   wire logic grp_on = !ucode.mask_sel[1];
   wire logic [7:0] imm = {ucode.bus_ctl, ucode.group, ucode.special};
   wire logic [2:0] bus_hot = {ucode.bus_ctl == `BUSC_WRITE, ucode.bus_ctl == `BUSC_READ,
      ucode.bus_ctl == `BUSC_END};
   wire logic [2:0] dest_hot = {ucode.dest == `DEST_CYL, ucode.dest == `DEST_QUEUE,
      ucode.dest == `DEST_UNIT};
   wire logic [3:0] crc_hot = {sp[0], sp[1], sp[2], sp[3]};
   wire logic src_off = src == `SRC_FLOAT_A || src == `SRC_FLOAT_B || src == `SRC_FLOAT_C;
   wire logic to_nxt = !take && (br == ucode_pkg::BR_JMP || br == ucode_pkg::BR_CALL
      || (t && (br == ucode_pkg::BR_JMP_T || br == ucode_pkg::BR_RET_F))
      || (!t && (br == ucode_pkg::BR_JMP_F || br == ucode_pkg::BR_RET_T)));
   wire logic to_inc = !take && (br == ucode_pkg::BR_INC
      || (!t && br == ucode_pkg::BR_JMP_T) || (t && br == ucode_pkg::BR_JMP_F));
   logic run_reg;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      run_reg <= rst_b;
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!run_reg);
   sequence s_call;
      !take && br == ucode_pkg::BR_CALL;
   endsequence
   sequence s_ret;
      !take && br == ucode_pkg::BR_RET;
   endsequence
   property p_call_ret;
      s_call ##1 s_ret |=> micro_addr == $past(micro_addr, 2) + one_a;
   endproperty
   a_call_ret: assert property (p_call_ret)
      else $error("return address wrong");
   property p_nxt;
      to_nxt |=> micro_addr == $past(ucode.next_address_field);
   endproperty
   a_nxt: assert property (p_nxt)
      else $error("branch target wrong");
   property p_inc;
      to_inc |=> micro_addr == $past(micro_addr) + one_a;
   endproperty
   a_inc: assert property (p_inc)
      else $error("increment wrong");
   property p_slave;
      1 |=> slave_trap == $past(take) && slave_enable == $past(ucode.slave_en);
   endproperty
   a_slave: assert property (p_slave)
      else $error("slave trap or enable wrong");
   property p_src;
      1 |=> src_enable == ($past(src_off) ? 8'h00 : 8'h01 << $past(src));
   endproperty
   a_src: assert property (p_src)
      else $error("source enable wrong");
   property p_mask;
      (!grp_on && ucode.word_sel == `WSEL_FULL) |=> mask_bus == {{8{~$past(imm[7])}}, ~$past(imm)};
   endproperty
   a_mask: assert property (p_mask)
      else $error("mask bus wrong");
   property p_bus;
      1 |=> bus_cmd == ($past(grp_on) ? $past(bus_hot) : 3'h0);
   endproperty
   a_bus: assert property (p_bus)
      else $error("bus command wrong");
   property p_dest;
      1 |=> ##1 dest_load == $past(dest_hot, 2);
   endproperty
   a_dest: assert property (p_dest)
      else $error("destination load wrong");
   property p_g0;
      (grp_on && ucode.group == `GRP_PULSE && g0_strobed[sp]) |-> ##2 group0_pulse[$past(sp, 2)];
   endproperty
   a_g0: assert property (p_g0)
      else $error("strobed pulse missing");
   property p_ctl;
      (grp_on && ucode.group == `GRP_CTL) |=> ctl_flags[$past(sp[3:1])] == $past(sp[0]);
   endproperty
   a_ctl: assert property (p_ctl)
      else $error("control flag wrong");
   property p_hold;
      !(grp_on && ucode.group == `GRP_CTL) |=> $stable(ctl_flags);
   endproperty
   a_hold: assert property (p_hold)
      else $error("control flag changed");
   property p_crc;
      1 |=> crc_flags == ($past(grp_on) && $past(ucode.group) == `GRP_FLAGS ? $past(crc_hot) : '0);
   endproperty
   a_crc: assert property (p_crc)
      else $error("flag group wrong");
   property p_clk;
      1 |=> array_clk_en == !$past(ucode.clk_stop)
         && carry_in == ($past(ucode.word_sel) != `WSEL_SHIFT && $past(ucode.carry));
   endproperty
   a_clk: assert property (p_clk)
      else $error("array clock or carry wrong");
endmodule : disk_ctrl_microinstruction_decoder_asserts

bind disk_ctrl_microinstruction_decoder disk_ctrl_microinstruction_decoder_asserts #(
   .ADDR_W(ADDR_W),
   .STACK_DEPTH(STACK_DEPTH)
) disk_ctrl_microinstruction_decoder_asserts_i (
   .ref_clk(ref_clk), .rst_b(rst_b), .ucode(ucode), .branch_test_bit(branch_test_bit),
   .slave_request(slave_request), .micro_addr(micro_addr), .slave_trap(slave_trap),
   .slave_enable(slave_enable), .array_clk_en(array_clk_en), .mask_bus(mask_bus),
   .carry_in(carry_in), .src_enable(src_enable), .dest_load(dest_load), .bus_cmd(bus_cmd),
   .group0_pulse(group0_pulse), .ctl_flags(ctl_flags), .crc_flags(crc_flags)
);

//--- ucode_rom.sv
// Behavioural microprogram store feeding words to the decoder.
`timescale 1ns/10ps
module ucode_rom (
   input wire logic [9:0] micro_addr,
   output ucode_pkg::ucode_s ucode
);
   // Words are loaded straight into this array; unwritten words stay all zero.
   ucode_pkg::ucode_s mem [0:1023] = '{default: '0};
   assign ucode = mem[micro_addr];
endmodule : ucode_rom

//--- disk_ctrl_microinstruction_decoder_bench.sv
// Self-checking bench for the microinstruction decoder.
`timescale 1ns/10ps
`include "ucode_map.svh"
module disk_ctrl_microinstruction_decoder_bench;
   logic ref_clk, rst_b, branch_test_bit, slave_request, reg_wr, reg_rd;
   logic slave_trap, slave_enable, array_clk_en, carry_in, shift_fill;
   logic [1:0] reg_addr, word_sel;
   logic [15:0] reg_wdata, reg_rdata, mask_bus, group0_pulse;
   logic [9:0] micro_addr;
   logic [7:0] src_enable;
   ucode_pkg::ucode_s ucode, u;
   ucode_pkg::dest_load_s dest_load;
   ucode_pkg::bus_cmd_s bus_cmd;
   ucode_pkg::ctl_flags_s ctl_flags;
   ucode_pkg::drive_lines_s drive_lines;
   ucode_pkg::crc_flags_s crc_flags;
   int err_count, checked, cyc;

   disk_ctrl_microinstruction_decoder disk_ctrl_microinstruction_decoder_i (
      .ref_clk(ref_clk), .rst_b(rst_b), .ucode(ucode), .branch_test_bit(branch_test_bit),
      .slave_request(slave_request), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .micro_addr(micro_addr),
      .slave_trap(slave_trap), .slave_enable(slave_enable), .array_clk_en(array_clk_en),
      .word_sel(word_sel), .mask_bus(mask_bus), .carry_in(carry_in), .shift_fill(shift_fill),
      .src_enable(src_enable), .dest_load(dest_load), .bus_cmd(bus_cmd),
      .group0_pulse(group0_pulse), .ctl_flags(ctl_flags), .drive_lines(drive_lines),
      .crc_flags(crc_flags));
   ucode_rom ucode_rom_i (.micro_addr(micro_addr), .ucode(ucode));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step

   task automatic restart();
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1;
   endtask : restart

   task automatic word(input int a, input logic [2:0] br, input int nxt);
      u = '0;
      u.branch = ucode_pkg::branch_e'(br);
      u.next_address_field = 10'(nxt);
      ucode_rom_i.mem[a] = u;
   endtask : word

   task automatic dec(input int a, input logic [1:0] g, input logic [3:0] s,
      input logic [1:0] b, input logic [1:0] d);
      u = '0;
      u.group = g;
      u.special = s;
      u.bus_ctl = b;
      u.dest = d;
      ucode_rom_i.mem[a] = u;
   endtask : dec

   task automatic run_path(input logic tst, input int n, input int p[10]);
      branch_test_bit <= tst;
      restart();
      for (int i = 0; i < n; i++) begin
         chk(16'(micro_addr), 16'(p[i]));
         step();
      end
   endtask : run_path

   task automatic t_branch();
      @(posedge ref_clk);
      word(0, 3'h1, 3);
      word(4, 3'h4, 10);
      word(10, 3'h5, 20);
      word(20, 3'h6, 9);
      word(5, 3'h2, 7);
      word(6, 3'h3, 9);
      word(7, 3'h6, 9);
      word(9, 3'h4, 12);
      word(12, 3'h7, 0);
      run_path(1'b1, 9, '{0, 3, 4, 10, 5, 7, 9, 12, 10, 0});
      run_path(1'b0, 10, '{0, 3, 4, 10, 20, 5, 6, 9, 12, 10});
      $display("branch test done");
   endtask : t_branch

   task automatic t_decode();
      dec(0, `GRP_CTL, 4'h1, `BUSC_READ, `DEST_UNIT);
      ucode_rom_i.mem[0].src = 3'h3;
      dec(1, `GRP_DRIVE, 4'hD, `BUSC_WRITE, `DEST_QUEUE);
      dec(2, `GRP_PULSE, `G0_MASTER_CLR, `BUSC_END, `DEST_CYL);
      dec(3, `GRP_FLAGS, 4'hA, 2'h0, 2'h0);
      dec(4, 2'h0, 4'h0, 2'h0, 2'h0);
      ucode_rom_i.mem[4].mask_sel = 2'h2;
      ucode_rom_i.mem[4].word_sel = `WSEL_FULL;
      dec(5, `GRP_CTL, 4'h0, 2'h0, 2'h0);
      dec(6, `GRP_PULSE, `G0_CLK_STOP, 2'h0, 2'h0);
      ucode_rom_i.mem[6].clk_stop = 1'b1;
      ucode_rom_i.mem[6].carry = 1'b1;
      ucode_rom_i.mem[6].word_sel = `WSEL_RIGHT;
      dec(7, 2'h0, 4'h0, 2'h0, 2'h0);
      ucode_rom_i.mem[7].word_sel = `WSEL_SHIFT;
      ucode_rom_i.mem[7].carry = 1'b1;
      restart();
      step();
      chk(16'(ctl_flags), 16'h0001);
      chk(16'(bus_cmd), 16'h0002);
      chk(16'(src_enable), 16'h0008);
      step();
      chk(16'(drive_lines), 16'h0040);
      chk(16'(bus_cmd), 16'h0004);
      chk(16'(dest_load), 16'h0001);
      step();
      chk(16'(bus_cmd), 16'h0001);
      chk(group0_pulse, 16'h0000);
      step();
      chk(group0_pulse, 16'h0004);
      chk(16'(crc_flags), 16'h0005);
      chk(16'(dest_load), 16'h0004);
      step();
      chk(mask_bus, 16'hFFFF);
      chk(16'(ctl_flags), 16'h0001);
      step();
      chk(16'(ctl_flags), 16'h0000);
      step();
      chk(group0_pulse, 16'h0002);
      chk(16'({array_clk_en, carry_in, word_sel}), 16'h0005);
      step();
      chk(16'({carry_in, shift_fill}), 16'h0001);
      $display("decode test done");
   endtask : t_decode

   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd

   task automatic t_regs();
      rd(2'h0, 16'h03F0);
      wr(2'h0, 16'h0155);
      rd(2'h0, 16'h0155);
      wr(2'h2, 16'hFFFF);
      rd(2'h2, 16'h4001);
      rd(2'h3, 16'h0000);
      $display("register test done");
   endtask : t_regs

   task automatic t_trap();
      word(0, 3'h1, 7);
      ucode_rom_i.mem[0].slave_en = 1'b1;
      word(10'h3F0, 3'h7, 0);
      slave_request <= 1'b1;
      restart();
      step();
      chk(16'(micro_addr), 16'h03F0);
      chk(16'({slave_trap, slave_enable}), 16'h0003);
      step();
      chk(16'(micro_addr), 16'h0007);
      step();
      chk(16'({micro_addr, slave_trap, slave_enable}), 16'h0020);
      $display("trap test done");
   endtask : t_trap

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // Far above the run length, so it only catches a hang.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         end_of_test();
      end
   end

   initial begin
      rst_b = 1'b0;
      branch_test_bit = 1'b0;
      slave_request = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      t_branch();
      t_decode();
      t_regs();
      t_trap();
      end_of_test();
   end
endmodule : disk_ctrl_microinstruction_decoder_bench
